// File: dv/cacr_batt_model.sv
`default_nettype none
// battery comparator behind the level monitor: answers for the band being probed
module cacr_batt_model (
	input  wire logic       none_i,
	input  wire logic [1:0] band_i,
	input  wire logic [1:0] lvl_band_i,
	input  wire logic [2:0] lvl_step_i,
	output logic      [2:0] step_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// bands above the cell read zero, so the search has to walk down to it
	always_comb begin
		if (none_i || band_i > lvl_band_i) begin
			step_o = 3'h0;
		end else if (band_i == lvl_band_i) begin
			step_o = lvl_step_i;
		end else begin
			step_o = 3'h7; // cell is above this whole band
		end
	end
endmodule : cacr_batt_model
`default_nettype wire

// File: dv/cacr_regs_tb_top.sv
`default_nettype none
module cacr_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cacr_pkg::*;
	// short ms keeps the 15 s hold inside the run
	localparam int          MS        = 2;
	localparam int          RST_MS[4] = '{5000, 9000, 11000, 15000};
	localparam logic [11:0] UV[8]     = '{12'h000, 12'h000, 12'hBB8, 12'h000,
		12'hA28, 12'h960, 12'h898, 12'h898};
	localparam logic [4:0]  LC[4]     = '{5'h00, 5'h19, 5'h1A, 5'h1F};
	localparam logic [4:0]  MC[6]     = '{5'h00, 5'h1F, 5'h16, 5'h0B, 5'h02, 5'h11};
	logic        clk_i = 1'b0, resetn_i = 1'b0, wr = 1'b0, rd = 1'b0, lp = 1'b0;
	logic        ctl = 1'b0, pb_n = 1'b1, pg_n = 1'b1, vin_ok = 1'b0;
	logic        ext_v = 1'b0, m_none = 1'b0;
	cacr_byte_t  addr = 8'h00, wdata = 8'h00, rdata;
	logic [9:0]  lim;
	logic [11:0] tgt, uv;
	logic [4:0]  code, m_lvl = 5'h00;
	logic [2:0]  step;
	logic [1:0]  band;
	logic        ldo_on, pass, uv_ok, spin, brst, ship, hiz, busy;
	int          num_errors = 0, checked = 0;

	always #4 clk_i = ~clk_i;

	cacr_regs #(.MS_CYC(MS)) uut (
		.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.ldo_control_pin_i(ctl), .push_button_input_n_i(pb_n),
		.power_good_n_i(pg_n), .vin_in_window_i(vin_ok), .input_limit_pin_ext_valid_i(ext_v),
		.input_limit_pin_ext_ma_i(10'h1F4), .mon_step_i(step), .low_power_req_i(lp),
		.ldo_on_o(ldo_on), .ldo_code_o(code), .ldo_target_mv_o(tgt),
		.ldo_pass_through_o(pass), .input_limit_ma_o(lim), .battery_undervoltage_code_mv_o(uv),
		.battery_undervoltage_code_valid_o(uv_ok), .shared_pin_o(spin), .button_reset_o(brst),
		.enter_ship_o(ship), .enter_hiz_o(hiz), .mon_band_o(band), .mon_busy_o(busy)
	);

	cacr_batt_model batt (.none_i(m_none), .band_i(band), .lvl_band_i(m_lvl[4:3]),
		.lvl_step_i(m_lvl[2:0]), .step_o(step));

	task automatic wrap_up();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic chkb(input string what, input logic seen, input logic exp);
		chk(what, {11'h0, seen}, {11'h0, exp});
	endtask : chkb

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick

	// one-cycle strobes, launched and dropped on falling edges
	task automatic wr_reg(input cacr_byte_t a, input cacr_byte_t d);
		@(negedge clk_i);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
	endtask : wr_reg

	// read data lands on the same edge that takes the strobe
	task automatic rd_chk(input cacr_byte_t a, input cacr_byte_t exp, input string what);
		@(negedge clk_i);
		addr = a;
		rd = 1'b1;
		@(negedge clk_i);
		rd = 1'b0;
		@(negedge clk_i);
		chk(what, {4'h0, rdata}, {4'h0, exp});
	endtask : rd_chk

	task automatic idle_wait();
		int n;
		n = 0;
		tick(2);
		while (busy !== 1'b0 && n < 60) begin
			tick(1);
			n++;
		end
		if (n == 60) begin
			num_errors++;
			$display("Error monitor busy expected 0 seen 1");
			wrap_up();
		end
	endtask : idle_wait

	// hold the button for ms, then read the flags (read also clears them)
	task automatic wake(input logic [1:0] sel, input int ms, input logic [1:0] exp);
		wr_reg(8'h08, {sel, 3'h7, 3'h0});
		rd_chk(8'h08, {sel, 3'h7, 3'h0}, "flags clear");
		pb_n = 1'b0;
		tick(ms * MS);
		pb_n = 1'b1;
		tick(4);
		rd_chk(8'h08, {sel, 3'h7, 1'b0, exp}, "wake flags");
	endtask : wake

	// long press; with the input gate on, reset waits for a valid input
	task automatic rpress(input logic [1:0] sel, input logic post, input logic gate);
		int n;
		n = 0;
		wr_reg(8'h07, {7'h00, gate});
		wr_reg(8'h08, {2'h1, post, sel, 3'h0});
		pb_n = 1'b0;
		while (brst !== 1'b1 && n < (RST_MS[sel] + 20) * MS) begin
			tick(1);
			n++;
		end
		if (gate) begin
			chkb("gated reset", brst, 1'b0);
			vin_ok = 1'b1;
			n = 0;
			while (brst !== 1'b1 && n < 8) begin
				tick(1);
				n++;
			end
			chkb("vin reset", brst, 1'b1);
		end else begin
			chkb("reset time", n >= RST_MS[sel] * MS && n <= RST_MS[sel] * MS + 8, 1'b1);
		end
		chkb("ship", ship, ~post);
		chkb("hiz", hiz, post);
		// a reset that never came has used up its wait: stop here
		if (brst !== 1'b1) begin
			wrap_up();
		end
		pb_n = 1'b1;
		vin_ok = 1'b0;
		tick(4);
	endtask : rpress

	initial begin
		tick(4);
		resetn_i = 1'b1;
		tick(2);
		// defaults and an unmapped place
		rd_chk(8'h07, 8'h7C, "ldo rst");
		rd_chk(8'h08, 8'h68, "pb rst");
		rd_chk(8'h09, 8'h0A, "input_limit_pin rst");
		rd_chk(8'h0A, 8'h00, "mon rst");
		rd_chk(8'h0B, 8'h00, "unmapped");
		chk("input_limit_pin mA", {2'h0, lim}, 12'h064);
		chk("uv mV", uv, 12'hBB8);
		foreach (LC[i]) begin
			wr_reg(8'h07, {1'b0, LC[i], 2'h0});
			tick(4);
			chk("ldo mV", tgt, 12'(800 + 100 * LC[i]));
			chkb("ldo pass", pass, (800 + 100 * LC[i]) > 3300);
		end
		// code must not move while the pin keeps the output on
		ctl = 1'b1;
		tick(4);
		chkb("ldo on", ldo_on, 1'b1);
		wr_reg(8'h07, 8'h14);
		tick(4);
		chk("ldo frozen", {7'h0, code}, 12'h01F);
		ctl = 1'b0;
		tick(4);
		chk("ldo applied", {7'h0, code}, 12'h005);
		wr_reg(8'h07, 8'hFF);
		tick(4);
		chk("ldo en frozen", {7'h0, code}, 12'h005);
		rd_chk(8'h07, 8'hFD, "ldo ro bit");
		wr_reg(8'h07, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr_reg(8'h09, {2'h0, 3'(c), 3'(c)});
			tick(4);
			chk("input_limit_pin mA", {2'h0, lim}, 12'(50 + 50 * c));
			chk("uv mV", uv, UV[c]);
			chkb("uv ok", uv_ok, UV[c] != 12'h000);
		end
		ext_v = 1'b1;
		tick(5);
		chk("input_limit_pin ext", {2'h0, lim}, 12'h1F4);
		ext_v = 1'b0;
		// shared pin source
		pg_n = 1'b0;
		tick(5);
		chkb("pin pg", spin, 1'b0);
		pg_n = 1'b1;
		tick(5);
		chkb("pin pg off", spin, 1'b1);
		wr_reg(8'h08, 8'h6C);
		pb_n = 1'b0;
		tick(5);
		chkb("pin button", spin, 1'b0);
		pb_n = 1'b1;
		tick(5);
		chkb("pin button up", spin, 1'b1);
		wake(2'h0, 70, 2'h0);
		wake(2'h0, 90, 2'h2);
		wake(2'h2, 590, 2'h0);
		wake(2'h2, 610, 2'h2);
		wake(2'h0, 1010, 2'h3);
		wake(2'h1, 1490, 2'h2);
		wake(2'h1, 1510, 2'h3);
		// band search: none found, each band, last one from a low-power request
		for (int i = 0; i < 6; i++) begin
			m_none = (i == 0);
			m_lvl = MC[i];
			if (i == 5) begin
				@(negedge clk_i);
				lp = 1'b1;
				@(negedge clk_i);
				lp = 1'b0;
			end else begin
				wr_reg(8'h0A, 8'h80);
			end
			idle_wait();
			rd_chk(8'h0A, {1'b0, MC[i], 2'h0}, "monitor");
			if (i == 1) begin
				wr_reg(8'h0A, 8'h7F);
				rd_chk(8'h0A, 8'h7C, "mon ro");
			end
		end
		wr_reg(8'h08, 8'h04);
		wr_reg(8'h09, 8'h3F);
		wr_reg(8'h09, 8'h80);
		rd_chk(8'h07, 8'h7C, "grst ldo");
		rd_chk(8'h08, 8'h68, "grst pb");
		rd_chk(8'h09, 8'h0A, "grst input_limit_pin");
		rd_chk(8'h0A, 8'h00, "grst mon");
		rpress(2'h0, 1'b0, 1'b0);
		rpress(2'h3, 1'b1, 1'b0);
		rpress(2'h2, 1'b0, 1'b0);
		rpress(2'h1, 1'b1, 1'b1);
		wrap_up();
	end
endmodule : cacr_regs_tb_top
`default_nettype wire

// File: rtl/cacr_params.svh
`ifndef CACR_PARAMS_SVH
`define CACR_PARAMS_SVH
// register offsets
`define CACR_LDO_OFS      8'h07
`define CACR_PB_OFS       8'h08
`define CACR_INPUT_LIMIT_PIN_OFS     8'h09
`define CACR_MON_OFS      8'h0A
// reset values
`define CACR_LDO_RST      8'h7C
`define CACR_PB_RST       8'h68
`define CACR_INPUT_LIMIT_PIN_RST     8'h0A
`define CACR_MON_RST      8'h00
// host-writable bits per register
`define CACR_LDO_WMASK    8'hFD
`define CACR_PB_WMASK     8'hFC
`define CACR_INPUT_LIMIT_PIN_WMASK   8'h7F
// field positions
`define CACR_LDO_EN_BIT   7
`define CACR_LDO_CODE_HI  6
`define CACR_LDO_CODE_LO  2
`define CACR_REQ_VIN_BIT  0
`define CACR_WAKE_S_BIT   7
`define CACR_WAKE_L_BIT   6
`define CACR_POST_BIT     5
`define CACR_RST_SEL_HI   4
`define CACR_RST_SEL_LO   3
`define CACR_PIN_SEL_BIT  2
`define CACR_FLAG_S_BIT   1
`define CACR_FLAG_L_BIT   0
`define CACR_GRST_BIT     7
`define CACR_INPUT_CURRENT_LIMIT_CODE_HI     5
`define CACR_INPUT_CURRENT_LIMIT_CODE_LO     3
`define CACR_BATTERY_UNDERVOLTAGE_CODE_HI     2
`define CACR_BATTERY_UNDERVOLTAGE_CODE_LO     0
`define CACR_TRIG_BIT     7
`define CACR_RES_HI       6
`define CACR_RES_LO       2
// analogue scaling, mV and mA
`define CACR_LDO_BASE_MV  12'h320
`define CACR_LDO_STEP_MV  12'h064
`define CACR_LDO_PASS_MV  12'hCE4
`define CACR_INPUT_LIMIT_PIN_BASE_MA 10'h032
`define CACR_INPUT_LIMIT_PIN_STEP_MA 10'h032
`define CACR_BATTERY_UNDERVOLTAGE_CODE_3V0    12'hBB8
`define CACR_BATTERY_UNDERVOLTAGE_CODE_2V6    12'hA28
`define CACR_BATTERY_UNDERVOLTAGE_CODE_2V4    12'h960
`define CACR_BATTERY_UNDERVOLTAGE_CODE_2V2    12'h898
// timing: clock rate and press times in ms
`define CACR_CLK_HZ       125000000
`define CACR_MS_CYC       (`CACR_CLK_HZ / 1000)
`define CACR_WAKE_S0_MS   14'h0050
`define CACR_WAKE_S1_MS   14'h0258
`define CACR_WAKE_L0_MS   14'h03E8
`define CACR_WAKE_L1_MS   14'h05DC
`define CACR_RST_T0_MS    14'h1388
`define CACR_RST_T1_MS    14'h2328
`define CACR_RST_T2_MS    14'h2AF8
`define CACR_RST_T3_MS    14'h3A98
`define CACR_MON_SETTLE   4'h8
`endif

// File: rtl/cacr_pkg.sv
`default_nettype none
package cacr_pkg;
	typedef logic [7:0] cacr_byte_t;
	typedef logic [13:0] cacr_ms_t;
	typedef enum logic [1:0] {MON_IDLE, MON_SETTLE, MON_EVAL} cacr_mon_state_t;
endpackage : cacr_pkg
`default_nettype wire

// File: rtl/cacr_press_timer.sv
`include "cacr_params.svh"
`default_nettype none
module cacr_press_timer #(
	parameter int unsigned MS_CYC = `CACR_MS_CYC
) (
	input  wire logic           clk_i,
	input  wire logic           resetn_i,
	input  wire logic           pressed_i,
	input  wire cacr_pkg::cacr_ms_t short_ms_i,
	input  wire cacr_pkg::cacr_ms_t long_ms_i,
	input  wire cacr_pkg::cacr_ms_t reset_ms_i,
	output logic                hit_short_o,
	output logic                hit_long_o,
	output logic                hit_reset_o
);
	import cacr_pkg::*;
	localparam int unsigned PW = $clog2(MS_CYC);
	logic [PW-1:0] pre_ff, nxt_pre;
	cacr_ms_t      ms_ff, nxt_ms, ms_inc;
	logic          tick;
	logic          nxt_hs, nxt_hl, nxt_hr;

	// ms prescaler and press-length counter; release restarts both
	always_comb begin
		tick    = (pre_ff == PW'(MS_CYC - 1));
		ms_inc  = ms_ff + 14'h0001;
		nxt_pre = tick ? '0 : pre_ff + PW'(1);
		nxt_ms  = ms_ff;
		if (tick && ms_ff != 14'h3FFF) begin
			nxt_ms = ms_inc; // saturate so a stuck button never wraps
		end
		if (!pressed_i) begin
			nxt_pre = '0;
			nxt_ms  = '0;
		end
		// one pulse when the press first reaches each threshold
		nxt_hs = pressed_i && tick && ms_inc == short_ms_i;
		nxt_hl = pressed_i && tick && ms_inc == long_ms_i;
		nxt_hr = pressed_i && tick && ms_inc == reset_ms_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pre_ff      <= '0;
			ms_ff       <= '0;
			hit_short_o <= 1'b0;
			hit_long_o  <= 1'b0;
			hit_reset_o <= 1'b0;
		end else begin
			pre_ff      <= nxt_pre;
			ms_ff       <= nxt_ms;
			hit_short_o <= nxt_hs;
			hit_long_o  <= nxt_hl;
			hit_reset_o <= nxt_hr;
		end
	end
endmodule : cacr_press_timer
`default_nettype wire

// File: rtl/cacr_regs.sv
`include "cacr_params.svh"
`default_nettype none
module cacr_regs #(
	parameter int unsigned MS_CYC = `CACR_MS_CYC
) (
	input  wire logic                clk_i,
	input  wire logic                resetn_i,
	input  wire cacr_pkg::cacr_byte_t reg_addr_i,
	input  wire cacr_pkg::cacr_byte_t reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output cacr_pkg::cacr_byte_t     reg_rdata_o,
	input  wire logic                ldo_control_pin_i,
	input  wire logic                push_button_input_n_i,
	input  wire logic                power_good_n_i,
	input  wire logic                vin_in_window_i,
	input  wire logic                input_limit_pin_ext_valid_i,
	input  wire logic [9:0]          input_limit_pin_ext_ma_i,
	input  wire logic [2:0]          mon_step_i,
	input  wire logic                low_power_req_i,
	output logic                     ldo_on_o,
	output logic [4:0]               ldo_code_o,
	output logic [11:0]              ldo_target_mv_o,
	output logic                     ldo_pass_through_o,
	output logic [9:0]               input_limit_ma_o,
	output logic [11:0]              battery_undervoltage_code_mv_o,
	output logic                     battery_undervoltage_code_valid_o,
	output logic                     shared_pin_o,
	output logic                     button_reset_o,
	output logic                     enter_ship_o,
	output logic                     enter_hiz_o,
	output logic [1:0]               mon_band_o,
	output logic                     mon_busy_o
);
	import cacr_pkg::*;
	localparam int unsigned SW = 18;
	localparam logic [SW-1:0] SYNC_RST = 18'h30000;

	// pin synchronisers, one pair of flops per bit
	logic [SW-1:0] pin_raw, s1_ff, s2_ff;
	assign pin_raw = {push_button_input_n_i, power_good_n_i, ldo_control_pin_i,
		vin_in_window_i, input_limit_pin_ext_valid_i, input_limit_pin_ext_ma_i, mon_step_i};
	for (genvar i = 0; i < SW; i++) begin : g_sync
		always_ff @(posedge clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				s1_ff[i] <= SYNC_RST[i];
				s2_ff[i] <= SYNC_RST[i];
			end else begin
				s1_ff[i] <= pin_raw[i];
				s2_ff[i] <= s1_ff[i];
			end
		end
	end
	logic       pb_n_s, pg_n_s, ctrl_s, vin_ok_s, ext_valid_s;
	logic [9:0] ext_ma_s;
	logic [2:0] step_s;
	assign {pb_n_s, pg_n_s, ctrl_s, vin_ok_s, ext_valid_s, ext_ma_s, step_s} = s2_ff;

	// register file state
	cacr_byte_t ldo_ff, pb_ff, input_limit_pin_ff, mon_ff, rdata_ff;
	cacr_byte_t nxt_ldo, nxt_pb, nxt_input_limit_pin, nxt_mon, nxt_rdata;
	logic wr_ldo, wr_pb, wr_input_limit_pin, wr_mon, rd_pb, glob_rst, trig;
	logic hit_short, hit_long, hit_reset;
	logic mon_store;
	logic [4:0] mon_result;

	// address decode
	always_comb begin
		wr_ldo  = 1'b0;
		wr_pb   = 1'b0;
		wr_input_limit_pin = 1'b0;
		wr_mon  = 1'b0;
		if (reg_addr_i == `CACR_LDO_OFS) begin
			wr_ldo = reg_wr_i;
		end else if (reg_addr_i == `CACR_PB_OFS) begin
			wr_pb = reg_wr_i;
		end else if (reg_addr_i == `CACR_INPUT_LIMIT_PIN_OFS) begin
			wr_input_limit_pin = reg_wr_i;
		end else if (reg_addr_i == `CACR_MON_OFS) begin
			wr_mon = reg_wr_i;
		end
	end
	assign rd_pb    = reg_rd_i && reg_addr_i == `CACR_PB_OFS;
	assign glob_rst = wr_input_limit_pin && reg_wdata_i[`CACR_GRST_BIT];
	assign trig     = (wr_mon && reg_wdata_i[`CACR_TRIG_BIT]) || low_power_req_i;

	// register next values; flag set beats the clear of the same cycle
	always_comb begin
		nxt_ldo   = ldo_ff;
		nxt_pb    = pb_ff;
		nxt_input_limit_pin  = input_limit_pin_ff;
		nxt_mon   = mon_ff;
		nxt_rdata = rdata_ff;
		// only writable bits change; status and spare bits
		if (wr_ldo) begin
			nxt_ldo = (ldo_ff & ~`CACR_LDO_WMASK) | (reg_wdata_i & `CACR_LDO_WMASK);
		end
		if (wr_pb) begin
			nxt_pb = (pb_ff & ~`CACR_PB_WMASK) | (reg_wdata_i & `CACR_PB_WMASK);
		end
		if (wr_input_limit_pin) begin
			nxt_input_limit_pin = reg_wdata_i & `CACR_INPUT_LIMIT_PIN_WMASK; // reset bit never stored
		end
		if (rd_pb) begin
			nxt_pb[`CACR_FLAG_S_BIT] = 1'b0;
			nxt_pb[`CACR_FLAG_L_BIT] = 1'b0;
		end
		if (hit_short) begin
			nxt_pb[`CACR_FLAG_S_BIT] = 1'b1;
		end
		if (hit_long) begin
			nxt_pb[`CACR_FLAG_L_BIT] = 1'b1;
		end
		if (mon_store) begin
			nxt_mon[`CACR_RES_HI:`CACR_RES_LO] = mon_result;
		end
		if (glob_rst) begin
			nxt_ldo  = `CACR_LDO_RST;
			nxt_pb   = `CACR_PB_RST;
			nxt_input_limit_pin = `CACR_INPUT_LIMIT_PIN_RST;
			nxt_mon  = `CACR_MON_RST;
		end
		// read data, trigger and reset bits always read 0
		if (reg_rd_i) begin
			if (reg_addr_i == `CACR_LDO_OFS) begin
				nxt_rdata = ldo_ff;
			end else if (reg_addr_i == `CACR_PB_OFS) begin
				nxt_rdata = pb_ff;
			end else if (reg_addr_i == `CACR_INPUT_LIMIT_PIN_OFS) begin
				nxt_rdata = input_limit_pin_ff;
			end else if (reg_addr_i == `CACR_MON_OFS) begin
				nxt_rdata = mon_ff;
			end else begin
				nxt_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ldo_ff   <= `CACR_LDO_RST;
			pb_ff    <= `CACR_PB_RST;
			input_limit_pin_ff  <= `CACR_INPUT_LIMIT_PIN_RST;
			mon_ff   <= `CACR_MON_RST;
			rdata_ff <= 8'h00;
		end else begin
			ldo_ff   <= nxt_ldo;
			pb_ff    <= nxt_pb;
			input_limit_pin_ff  <= nxt_input_limit_pin;
			mon_ff   <= nxt_mon;
			rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata_o = rdata_ff;

	// derived analogue settings
	logic [4:0]  code_ff, nxt_code;
	logic [11:0] tgt_ff, nxt_tgt, bv_ff, nxt_bv;
	logic [9:0]  lim_ff, nxt_lim;
	logic        pass_ff, nxt_pass, bvv_ff, nxt_bvv, ldo_on;
	logic        on_ff;
	logic [2:0]  bcode;
	assign ldo_on = ldo_ff[`CACR_LDO_EN_BIT] || ctrl_s;
	assign bcode  = input_limit_pin_ff[`CACR_BATTERY_UNDERVOLTAGE_CODE_HI:`CACR_BATTERY_UNDERVOLTAGE_CODE_LO];

	always_comb begin
		// code is frozen while running to avoid a live voltage jump
		nxt_code = ldo_on ? code_ff : ldo_ff[`CACR_LDO_CODE_HI:`CACR_LDO_CODE_LO];
		nxt_tgt  = `CACR_LDO_BASE_MV + `CACR_LDO_STEP_MV * {7'h00, code_ff};
		nxt_pass = nxt_tgt > `CACR_LDO_PASS_MV;
		nxt_lim  = `CACR_INPUT_LIMIT_PIN_BASE_MA +
			`CACR_INPUT_LIMIT_PIN_STEP_MA * {7'h00, input_limit_pin_ff[`CACR_INPUT_CURRENT_LIMIT_CODE_HI:`CACR_INPUT_CURRENT_LIMIT_CODE_LO]};
		if (ext_valid_s) begin
			nxt_lim = ext_ma_s;
		end
		nxt_bvv = 1'b1;
		case (bcode)
			3'h2: nxt_bv = `CACR_BATTERY_UNDERVOLTAGE_CODE_3V0;
			3'h4: nxt_bv = `CACR_BATTERY_UNDERVOLTAGE_CODE_2V6;
			3'h5: nxt_bv = `CACR_BATTERY_UNDERVOLTAGE_CODE_2V4;
			3'h6,
			3'h7: nxt_bv = `CACR_BATTERY_UNDERVOLTAGE_CODE_2V2;
			default: begin
				nxt_bv  = 12'h000; // 000, 001 and 011 reserved
				nxt_bvv = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			code_ff <= 5'h1F;
			tgt_ff  <= 12'h000;
			pass_ff <= 1'b0;
			lim_ff  <= 10'h000;
			bv_ff   <= 12'h000;
			bvv_ff  <= 1'b0;
			on_ff   <= 1'b0;
		end else begin
			code_ff <= nxt_code;
			tgt_ff  <= nxt_tgt;
			pass_ff <= nxt_pass;
			lim_ff  <= nxt_lim;
			bv_ff   <= nxt_bv;
			bvv_ff  <= nxt_bvv;
			on_ff   <= ldo_on;
		end
	end
	assign ldo_on_o           = on_ff; // registered so the or of bit and pin cannot glitch
	assign ldo_code_o         = code_ff;
	assign ldo_target_mv_o    = tgt_ff;
	assign ldo_pass_through_o = pass_ff;
	assign input_limit_ma_o   = lim_ff;
	assign battery_undervoltage_code_mv_o         = bv_ff;
	assign battery_undervoltage_code_valid_o      = bvv_ff;

	// push-button timing
	cacr_ms_t short_ms, long_ms, reset_ms;
	always_comb begin
		short_ms = pb_ff[`CACR_WAKE_S_BIT] ? `CACR_WAKE_S1_MS : `CACR_WAKE_S0_MS;
		long_ms  = pb_ff[`CACR_WAKE_L_BIT] ? `CACR_WAKE_L1_MS : `CACR_WAKE_L0_MS;
		case (pb_ff[`CACR_RST_SEL_HI:`CACR_RST_SEL_LO])
			2'h0: reset_ms = `CACR_RST_T0_MS;
			2'h1: reset_ms = `CACR_RST_T1_MS;
			2'h2: reset_ms = `CACR_RST_T2_MS;
			default: reset_ms = `CACR_RST_T3_MS;
		endcase
	end

	cacr_press_timer #(
		.MS_CYC (MS_CYC)
	) u_timer (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.pressed_i   (!pb_n_s),
		.short_ms_i  (short_ms),
		.long_ms_i   (long_ms),
		.reset_ms_i  (reset_ms),
		.hit_short_o (hit_short),
		.hit_long_o  (hit_long),
		.hit_reset_o (hit_reset)
	);

	// reset waits, still held, for a valid input when that is required
	logic pend_ff, nxt_pend, brst_ff, ship_ff, hiz_ff, pin_ff;
	logic fire, req_in, post_sel, nxt_pin;
	assign req_in   = ldo_ff[`CACR_REQ_VIN_BIT];
	assign post_sel = pb_ff[`CACR_POST_BIT];
	always_comb begin
		fire     = pend_ff && (!req_in || vin_ok_s);
		nxt_pend = pend_ff;
		if (hit_reset) begin
			nxt_pend = 1'b1;
		end
		if (fire || pb_n_s) begin
			nxt_pend = 1'b0;
		end
		nxt_pin = pb_ff[`CACR_PIN_SEL_BIT] ? pb_n_s : pg_n_s;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pend_ff <= 1'b0;
			brst_ff <= 1'b0;
			ship_ff <= 1'b0;
			hiz_ff  <= 1'b0;
			pin_ff  <= 1'b1;
		end else begin
			pend_ff <= nxt_pend;
			brst_ff <= fire;
			ship_ff <= fire && !post_sel;
			hiz_ff  <= fire && post_sel;
			pin_ff  <= nxt_pin;
		end
	end
	assign button_reset_o = brst_ff;
	assign enter_ship_o   = ship_ff;
	assign enter_hiz_o    = hiz_ff;
	assign shared_pin_o   = pin_ff;

	// battery monitor band search
	cacr_mon_state_t state_ff, nxt_state;
	logic [1:0] band_ff, nxt_band;
	logic [3:0] cnt_ff, nxt_cnt;
	always_comb begin
		nxt_state  = state_ff;
		nxt_band   = band_ff;
		nxt_cnt    = cnt_ff;
		mon_store  = 1'b0;
		mon_result = 5'h00;
		case (state_ff)
			MON_IDLE: begin
				if (trig) begin
					nxt_state = MON_SETTLE;
					nxt_band  = 2'h3;
					nxt_cnt   = 4'h0;
				end
			end
			MON_SETTLE: begin
				// settle covers comparator delay plus two sync flops
				nxt_cnt = cnt_ff + 4'h1;
				if (cnt_ff == `CACR_MON_SETTLE - 4'h1) begin
					nxt_state = MON_EVAL;
				end
			end
			default: begin
				nxt_state = MON_IDLE;
				if (step_s != 3'h0) begin
					mon_store  = 1'b1;
					mon_result = {band_ff, step_s};
				end else if (band_ff == 2'h0) begin
					mon_store  = 1'b1;
				end else begin
					nxt_state = MON_SETTLE;
					nxt_band  = band_ff - 2'h1;
					nxt_cnt   = 4'h0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= MON_IDLE;
			band_ff  <= 2'h3;
			cnt_ff   <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			band_ff  <= nxt_band;
			cnt_ff   <= nxt_cnt;
		end
	end
	assign mon_band_o = band_ff;
	assign mon_busy_o = state_ff != MON_IDLE;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence s_eval_zero;
		state_ff == MON_EVAL && step_s == 3'h0;
	endsequence
	sequence s_start;
		state_ff == MON_IDLE && trig;
	endsequence

	a_ldo_code_hold: assert property (ldo_on |=> $stable(code_ff))
		else $error("output code changed while output on");
	a_ldo_scale: assert property (1'b1 |=> ldo_target_mv_o ==
		12'(`CACR_LDO_BASE_MV + `CACR_LDO_STEP_MV * {7'h00, $past(code_ff)}))
		else $error("output target does not match code");
	a_pass_mode: assert property (ldo_pass_through_o == (ldo_target_mv_o > `CACR_LDO_PASS_MV))
		else $error("pass-through does not match target");
	a_wake_set: assert property (hit_short && !glob_rst |=> pb_ff[`CACR_FLAG_S_BIT])
		else $error("short wake flag not set");
	a_wake_clear: assert property (rd_pb && !hit_short && !hit_long |=> pb_ff[1:0] == 2'h0)
		else $error("wake flags not cleared by read");
	a_glob_reset: assert property (glob_rst |=> ldo_ff == `CACR_LDO_RST &&
		pb_ff == `CACR_PB_RST && input_limit_pin_ff == `CACR_INPUT_LIMIT_PIN_RST)
		else $error("global reset did not restore defaults");
	a_trig_reads0: assert property (reg_rd_i && reg_addr_i == `CACR_MON_OFS |=>
		!reg_rdata_o[`CACR_TRIG_BIT])
		else $error("trigger bit read as one");
	a_reset_gate: assert property (button_reset_o |->
		$past(pend_ff) && (!$past(req_in) || $past(vin_ok_s)))
		else $error("button reset without its conditions");
	a_post_state: assert property (button_reset_o |->
		enter_hiz_o == $past(post_sel) && enter_ship_o != enter_hiz_o)
		else $error("wrong state after button reset");
	a_pin_func: assert property (1'b1 |=> shared_pin_o ==
		($past(pb_ff[`CACR_PIN_SEL_BIT]) ? $past(pb_n_s) : $past(pg_n_s)))
		else $error("shared pin function wrong");
	a_mon_start: assert property (s_start |=> state_ff == MON_SETTLE && band_ff == 2'h3
		##[1:40] state_ff == MON_IDLE)
		else $error("battery search did not start at top band or finish");
	a_mon_step: assert property (s_eval_zero ##0 band_ff != 2'h0 |=>
		state_ff == MON_SETTLE && band_ff == 2'($past(band_ff) - 2'h1))
		else $error("battery search did not step down");
	a_mon_empty: assert property (s_eval_zero ##0 band_ff == 2'h0 |=>
		mon_ff[`CACR_RES_HI:`CACR_RES_LO] == 5'h00)
		else $error("empty search not stored as zeros");
endmodule : cacr_regs
`default_nettype wire
